// file: ufd_params.svh
// constants for the endpoint buffer data port: offsets, reset values and timing
`ifndef UFD_PARAMS_SVH
`define UFD_PARAMS_SVH

// ==========================================================================
// register map
`define UFD_DATA_PORT_OFFSET     8'h44

// ==========================================================================
// reset values
`define UFD_DATA_RESET           16'h0000
`define UFD_COUNT_RESET          11'h000

// ==========================================================================
// field positions of the data port
`define UFD_LOW_BYTE_MSB         7
`define UFD_HIGH_BYTE_LSB        8

// ==========================================================================
// timing: port recovery after each accepted access
`define UFD_CLOCK_PERIOD_NS      10
`define UFD_RECOVERY_NS          20
`define UFD_RECOVERY_CYCLES      ((`UFD_RECOVERY_NS + `UFD_CLOCK_PERIOD_NS - 1) / `UFD_CLOCK_PERIOD_NS)

`endif

// file: ufd_pkg.sv
// types shared by the endpoint buffer data port files
package ufd_pkg;

   // ==========================================================================
   // data port access sequencing
   typedef enum logic {
      UFD_IDLE,
      UFD_HOLD
   } ufd_port_state_t;

   // ==========================================================================
   // widths of the data port and the byte count
   typedef logic [15:0] ufd_word_t;
   typedef logic [10:0] ufd_count_t;

endpackage : ufd_pkg

// file: ufd_buffer.sv
// byte-wide endpoint buffer with a two-lane write port and a two-byte read port
`timescale 1ns/10ps

module ufd_buffer #(
   parameter int DEPTH = 64,
   parameter int PTR_W = $clog2(DEPTH)
) (
   // clock
   input  wire logic              clock_i,
   // write port: low lane at the address, high lane at the next byte
   input  wire logic              wr_lo_i,
   input  wire logic              wr_hi_i,
   input  wire logic [PTR_W-1:0]  wr_addr_i,
   input  wire ufd_pkg::ufd_word_t wr_data_i,
   // read port: byte at the address in the low lane, next byte in the high lane
   input  wire logic [PTR_W-1:0]  rd_addr_i,
   output ufd_pkg::ufd_word_t     rd_data_o
);

   // ==========================================================================
   // storage
   logic [7:0]       mem [DEPTH];
   logic [PTR_W-1:0] wr_next_addr;
   logic [PTR_W-1:0] rd_next_addr;

   // wrap at the buffer end so a pair never writes outside the array
   assign wr_next_addr = (wr_addr_i == PTR_W'(DEPTH - 1)) ? '0 : wr_addr_i + PTR_W'(1);
   assign rd_next_addr = (rd_addr_i == PTR_W'(DEPTH - 1)) ? '0 : rd_addr_i + PTR_W'(1);

   always_ff @(posedge clock_i) begin
      if (wr_lo_i) begin
         mem[wr_addr_i] <= wr_data_i[7:0];
      end
      if (wr_hi_i) begin
         mem[wr_next_addr] <= wr_data_i[15:8];
      end
   end

   assign rd_data_o = {mem[rd_next_addr], mem[rd_addr_i]};

endmodule : ufd_buffer

// file: ufd_data_port.sv
// cpu-side data port of a usb endpoint buffer shared with the serial engine
//
// Summary of operation
// - out endpoint: each data port read returns received bytes from the buffer.
// - in endpoint: each data port write stores transmit data into the buffer.
// - 8-bit mode by width control or byte pin: upper bits invalid, low byte only.
// - 16-bit mode: a single-byte write counts as one transmit byte.
// - odd packet: write last byte as byte access, then set buffer valid; device sends.
// - while access pending, port inaccessible; buffer valid and byte count invalid.
// - writing buffer valid on in endpoint forces a short or zero-length packet.
// - out endpoint: receive byte count counts down as the host reads.
`timescale 1ns/10ps
`include "ufd_params.svh"

module ufd_data_port #(
   parameter int DEPTH      = 64,
   parameter int MAX_PACKET = 64,
   parameter int ADDR_W     = 8
) (
   // clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_n_i,
   // cpu bus
   input  wire logic                cs_n_i,
   input  wire logic                rd_n_i,
   input  wire logic                wr_n_i,
   input  wire logic [ADDR_W-1:0]   addr_i,
   input  wire logic                byte_hi_n_i,
   input  wire ufd_pkg::ufd_word_t  data_i,
   output ufd_pkg::ufd_word_t       data_o,
   output logic                     data_oe_o,
   // mode and control
   input  wire logic                bus_width_8_i,
   input  wire logic                byte_width_pin_n_i,
   input  wire logic                endpoint_direction_i,
   input  wire logic                buffer_valid_set_i,
   // status
   output logic                     access_pending_o,
   output logic                     buffer_valid_o,
   output ufd_pkg::ufd_count_t      receive_byte_count_o,
   // serial engine, receive side
   input  wire logic                sie_rx_valid_i,
   input  wire logic [7:0]          sie_rx_data_i,
   input  wire logic                sie_rx_done_i,
   // serial engine, transmit side
   input  wire logic                sie_tx_rd_i,
   input  wire logic                sie_tx_done_i,
   output logic [7:0]               sie_tx_data_o,
   output ufd_pkg::ufd_count_t      sie_tx_len_o,
   output logic                     sie_tx_ready_o
);

   // ==========================================================================
   // constants and declarations
   localparam int PTR_W        = $clog2(DEPTH);
   localparam int RECOVERY_CYC = (`UFD_RECOVERY_CYCLES < 1) ? 1 : `UFD_RECOVERY_CYCLES;
   localparam int BUSY_W       = $clog2(RECOVERY_CYC + 1);

   ufd_pkg::ufd_port_state_t state;
   logic [PTR_W-1:0]         ptr;
   ufd_pkg::ufd_count_t      count;
   logic                     valid;
   logic                     sie_active;
   logic [BUSY_W-1:0]        busy_cnt;

   logic [BUSY_W-1:0]        next_busy_cnt;
   logic                     next_sie_active;
   logic                     next_pending;
   logic                     sel;
   logic                     rd_act;
   logic                     wr_act;
   logic                     take_rd;
   logic                     take_wr;
   logic                     mode8;
   logic                     dir_in;
   logic [1:0]               rd_bytes;
   logic [1:0]               wr_bytes;
   logic                     cpu_rd_ok;
   logic                     cpu_wr_ok;
   logic                     sie_wr_ok;
   logic                     sie_rd_ok;
   logic                     mem_wr_lo;
   logic                     mem_wr_hi;
   ufd_pkg::ufd_word_t       mem_wr_data;
   ufd_pkg::ufd_word_t       mem_rd_data;

   // bytes moved by one access: none when nothing is left, one in byte mode or at the edge
   function automatic logic [1:0] ufd_bytes(input logic one_only, input ufd_pkg::ufd_count_t avail);
      if (avail == '0) begin
         return 2'h0;
      end else if (one_only || avail == 11'h001) begin
         return 2'h1;
      end else begin
         return 2'h2;
      end
   endfunction : ufd_bytes

   // pointer step with wrap at the buffer end
   function automatic logic [PTR_W-1:0] ufd_advance(input logic [PTR_W-1:0] p, input logic [1:0] n);
      logic [PTR_W:0] sum;
      sum = {1'b0, p} + (PTR_W + 1)'(n);
      if (sum >= (PTR_W + 1)'(DEPTH)) begin
         sum = sum - (PTR_W + 1)'(DEPTH);
      end
      return sum[PTR_W-1:0];
   endfunction : ufd_advance

   // ==========================================================================
   // access decode
   assign mode8   = bus_width_8_i | ~byte_width_pin_n_i;
   assign dir_in  = endpoint_direction_i;
   assign sel     = ~cs_n_i && (addr_i == ADDR_W'(`UFD_DATA_PORT_OFFSET));
   assign rd_act  = sel && ~rd_n_i;
   assign wr_act  = sel && ~wr_n_i;
   // a strobe that starts while pending is swallowed until it is released
   assign take_rd = (state == ufd_pkg::UFD_IDLE) && rd_act && ~access_pending_o;
   assign take_wr = (state == ufd_pkg::UFD_IDLE) && wr_act && ~rd_act && ~access_pending_o;

   assign rd_bytes  = ufd_bytes(mode8, count);
   // a lone low-lane strobe in 16-bit mode is a byte write
   assign wr_bytes  = ufd_bytes(mode8 | byte_hi_n_i, ufd_pkg::ufd_count_t'(DEPTH) - count);
   assign cpu_rd_ok = take_rd && ~dir_in && valid;
   assign cpu_wr_ok = take_wr && dir_in && ~valid;
   assign sie_wr_ok = sie_rx_valid_i && ~dir_in && ~valid && (count < ufd_pkg::ufd_count_t'(DEPTH));
   assign sie_rd_ok = sie_tx_rd_i && dir_in && valid;

   // ==========================================================================
   // buffer write steering: direction makes the two writers exclusive
   always_comb begin
      mem_wr_lo   = 1'b0;
      mem_wr_hi   = 1'b0;
      mem_wr_data = data_i;
      if (cpu_wr_ok) begin
         mem_wr_lo = wr_bytes != 2'h0;
         mem_wr_hi = wr_bytes == 2'h2;
      end else if (sie_wr_ok) begin
         mem_wr_lo   = 1'b1;
         mem_wr_data = {8'h00, sie_rx_data_i};
      end
   end

   ufd_buffer #(
      .DEPTH (DEPTH),
      .PTR_W (PTR_W)
   ) u_buffer (
      .clock_i   (clock_i),
      .wr_lo_i   (mem_wr_lo),
      .wr_hi_i   (mem_wr_hi),
      .wr_addr_i (ptr),
      .wr_data_i (mem_wr_data),
      .rd_addr_i (ptr),
      .rd_data_o (mem_rd_data)
   );

   // ==========================================================================
   // strobe sequencing: one action per strobe, however long it is held
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ufd_pkg::UFD_IDLE;
      end else begin
         unique case (state)
            ufd_pkg::UFD_IDLE: begin
               if (rd_act || wr_act) begin
                  state <= ufd_pkg::UFD_HOLD;
               end
            end
            ufd_pkg::UFD_HOLD: begin
               if (!rd_act && !wr_act) begin
                  state <= ufd_pkg::UFD_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================================
   // access pending: recovery after each access and while the engine owns the buffer
   always_comb begin
      next_busy_cnt   = busy_cnt;
      next_sie_active = sie_active;
      if (take_rd || take_wr) begin
         next_busy_cnt = BUSY_W'(RECOVERY_CYC);
      end else if (busy_cnt != '0) begin
         next_busy_cnt = busy_cnt - BUSY_W'(1);
      end
      if (sie_rx_done_i || sie_tx_done_i) begin
         next_sie_active = 1'b0;
      end else if (sie_wr_ok || sie_rd_ok) begin
         next_sie_active = 1'b1;
      end
      next_pending = (next_busy_cnt != '0) || next_sie_active;
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_cnt         <= '0;
         sie_active       <= 1'b0;
         access_pending_o <= 1'b0;
      end else begin
         busy_cnt         <= next_busy_cnt;
         sie_active       <= next_sie_active;
         access_pending_o <= next_pending;
      end
   end

   // ==========================================================================
   // shared pointer, byte count and buffer valid
   // the pointer fills from zero, rewinds when the buffer turns valid, then drains
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr   <= '0;
         count <= `UFD_COUNT_RESET;
         valid <= 1'b0;
      end else if (cpu_rd_ok) begin
         ptr   <= ufd_advance(ptr, rd_bytes);
         count <= count - ufd_pkg::ufd_count_t'(rd_bytes);
         if (count == ufd_pkg::ufd_count_t'(rd_bytes)) begin
            valid <= 1'b0;
            ptr   <= '0;
         end
      end else if (cpu_wr_ok) begin
         ptr   <= ufd_advance(ptr, wr_bytes);
         count <= count + ufd_pkg::ufd_count_t'(wr_bytes);
         // a full packet completes on its own
         if (count + ufd_pkg::ufd_count_t'(wr_bytes) >= ufd_pkg::ufd_count_t'(MAX_PACKET)) begin
            valid <= 1'b1;
            ptr   <= '0;
         end
      end else if (dir_in && buffer_valid_set_i && !valid) begin
         // forced completion sends what is staged, or nothing at all
         valid <= 1'b1;
         ptr   <= '0;
      end else if (sie_wr_ok) begin
         ptr   <= ufd_advance(ptr, 2'h1);
         count <= count + 11'h001;
      end else if (!dir_in && sie_rx_done_i && !valid) begin
         valid <= 1'b1;
         ptr   <= '0;
      end else if (sie_rd_ok) begin
         ptr <= ufd_advance(ptr, 2'h1);
      end else if (dir_in && sie_tx_done_i && valid) begin
         valid <= 1'b0;
         ptr   <= '0;
         count <= `UFD_COUNT_RESET;
      end
   end

   // ==========================================================================
   // cpu read data
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_o    <= `UFD_DATA_RESET;
         data_oe_o <= 1'b0;
      end else begin
         data_oe_o <= rd_act;
         if (cpu_rd_ok) begin
            // upper lane reads zero in byte mode or when only one byte was left
            data_o <= (rd_bytes == 2'h2) ? mem_rd_data
                                         : {8'h00, mem_rd_data[`UFD_LOW_BYTE_MSB:0]};
         end else if (rd_act && state == ufd_pkg::UFD_IDLE) begin
            // refused or misdirected reads never show stale data
            data_o <= `UFD_DATA_RESET;
         end
      end
   end

   // ==========================================================================
   // status and serial engine outputs
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buffer_valid_o       <= 1'b0;
         receive_byte_count_o <= `UFD_COUNT_RESET;
         sie_tx_data_o        <= 8'h00;
         sie_tx_len_o         <= `UFD_COUNT_RESET;
         sie_tx_ready_o       <= 1'b0;
      end else begin
         // hidden in step with the pending flag, so no stale status shows while it is high
         buffer_valid_o       <= valid && !next_pending;
         receive_byte_count_o <= (!dir_in && !next_pending) ? count : `UFD_COUNT_RESET;
         sie_tx_ready_o       <= dir_in && valid;
         sie_tx_len_o         <= dir_in ? count : `UFD_COUNT_RESET;
         if (sie_rd_ok) begin
            sie_tx_data_o <= mem_rd_data[`UFD_LOW_BYTE_MSB:0];
         end
      end
   end

endmodule : ufd_data_port

// file: ufd_data_port_asserts.sv
// concurrent checks on the data port pins
`timescale 1ns/10ps

module ufd_data_port_asserts #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic                clock_i,
   input wire logic                rst_n_i,
   // bus and mode
   input wire logic                cs_n_i,
   input wire logic                rd_n_i,
   input wire logic                wr_n_i,
   input wire logic [ADDR_W-1:0]   addr_i,
   input wire logic                bus_width_8_i,
   input wire logic                byte_width_pin_n_i,
   input wire logic                endpoint_direction_i,
   input wire logic                buffer_valid_set_i,
   input wire logic                sie_tx_done_i,
   // watched outputs
   input wire ufd_pkg::ufd_word_t  data_o,
   input wire logic                data_oe_o,
   input wire logic                access_pending_o,
   input wire logic                buffer_valid_o,
   input wire ufd_pkg::ufd_count_t receive_byte_count_o,
   input wire logic                sie_tx_ready_o
);
   // ======
   // data port selected on the bus
   wire port_sel = !cs_n_i && addr_i == ADDR_W'(8'h44);

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   a_read_drives_bus: assert property (port_sel && !rd_n_i |=> data_oe_o)
      else $error("read strobe did not enable the data bus");
   a_byte_mode_upper: assert property ($rose(data_oe_o) && $past(bus_width_8_i || !byte_width_pin_n_i)
      |-> data_o[15:8] == 8'h00)
      else $error("upper byte not zero in byte mode");
   a_access_starts_pend: assert property ($fell(rd_n_i & wr_n_i) && port_sel && !access_pending_o
      |=> access_pending_o)
      else $error("taken access did not raise pending");
   a_refused_read_zero: assert property ($fell(rd_n_i) && port_sel && access_pending_o
      |=> data_o == 16'h0000)
      else $error("read during pending returned data");
   a_pend_hides_status: assert property (access_pending_o
      |-> !buffer_valid_o && receive_byte_count_o == 11'h000)
      else $error("status visible while pending");
   a_in_count_zero: assert property (endpoint_direction_i [*2] |-> receive_byte_count_o == 11'h000)
      else $error("receive count nonzero on in endpoint");
   a_force_complete: assert property (buffer_valid_set_i && endpoint_direction_i && !sie_tx_ready_o
      |-> ##[1:2] sie_tx_ready_o)
      else $error("buffer valid write did not stage a packet");
   a_sent_clears: assert property (sie_tx_done_i |-> ##[1:2] !sie_tx_ready_o)
      else $error("packet sent but buffer still valid");
endmodule : ufd_data_port_asserts

bind ufd_data_port ufd_data_port_asserts #(.ADDR_W(ADDR_W)) u_asserts (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
   .addr_i(addr_i), .bus_width_8_i(bus_width_8_i), .byte_width_pin_n_i(byte_width_pin_n_i),
   .endpoint_direction_i(endpoint_direction_i), .buffer_valid_set_i(buffer_valid_set_i),
   .sie_tx_done_i(sie_tx_done_i), .data_o(data_o), .data_oe_o(data_oe_o),
   .access_pending_o(access_pending_o), .buffer_valid_o(buffer_valid_o),
   .receive_byte_count_o(receive_byte_count_o), .sie_tx_ready_o(sie_tx_ready_o));

// file: ufd_host_model.sv
// host cpu model making data port accesses on the parallel bus
`timescale 1ns/10ps

module ufd_host_model (
   // clock and status
   input  wire logic               clock_i,
   input  wire logic               access_pending_i,
   input  wire ufd_pkg::ufd_word_t rd_data_i,
   // parallel bus
   output logic                    cs_n_o,
   output logic                    rd_n_o,
   output logic                    wr_n_o,
   output logic [7:0]              addr_o,
   output logic                    byte_hi_n_o,
   output ufd_pkg::ufd_word_t      wr_data_o
);
   initial begin
      {cs_n_o, rd_n_o, wr_n_o, byte_hi_n_o} = 4'hF;
      addr_o = 8'h00;
      wr_data_o = 16'h0000;
   end

   // ======
   // one access; poll low skips the pending check to provoke a refusal
   task automatic access(input logic rd, input logic hi_n, input ufd_pkg::ufd_word_t wd,
                         input logic poll, output ufd_pkg::ufd_word_t rdat);
      int n = 0;
      @(negedge clock_i);
      while (poll && access_pending_i !== 1'h0 && n < 200) begin
         @(negedge clock_i);
         n++;
      end
      {cs_n_o, rd_n_o, wr_n_o, byte_hi_n_o} = {1'h0, !rd, rd, hi_n};
      addr_o = 8'h44;
      wr_data_o = wd;
      @(posedge clock_i);
      if (rd) @(posedge clock_i);
      #1;
      rdat = rd_data_i;
      @(negedge clock_i);
      {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
      // released lines flip so a stale value never passes for a live one
      addr_o = ~addr_o;
      wr_data_o = ~wr_data_o;
      @(negedge clock_i);
   endtask : access
endmodule : ufd_host_model

// file: tb_top.sv
// self-checking bench for the endpoint buffer data port
`timescale 1ns/10ps

module tb_top;
   logic clock_i, rst_n_i, cs_n_i, rd_n_i, wr_n_i, byte_hi_n_i, data_oe_o;
   logic bus_width_8_i, byte_width_pin_n_i, endpoint_direction_i, buffer_valid_set_i;
   logic access_pending_o, buffer_valid_o, sie_rx_valid_i, sie_rx_done_i;
   logic sie_tx_rd_i, sie_tx_done_i, sie_tx_ready_o;
   logic [7:0] addr_i, sie_rx_data_i, sie_tx_data_o;
   ufd_pkg::ufd_word_t data_i, data_o, rd_word;
   ufd_pkg::ufd_count_t receive_byte_count_o, sie_tx_len_o;
   logic [31:0] seed = 32'h9BF0;
   logic [7:0] q[$];
   int num_errors = 0, n_compared = 0, cycles = 0;
   wire w8 = bus_width_8_i || !byte_width_pin_n_i;

   ufd_data_port dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
      .wr_n_i(wr_n_i), .addr_i(addr_i), .byte_hi_n_i(byte_hi_n_i), .data_i(data_i), .data_o(data_o),
      .data_oe_o(data_oe_o), .bus_width_8_i(bus_width_8_i), .byte_width_pin_n_i(byte_width_pin_n_i),
      .endpoint_direction_i(endpoint_direction_i), .buffer_valid_set_i(buffer_valid_set_i),
      .access_pending_o(access_pending_o), .buffer_valid_o(buffer_valid_o),
      .receive_byte_count_o(receive_byte_count_o), .sie_rx_valid_i(sie_rx_valid_i),
      .sie_rx_data_i(sie_rx_data_i), .sie_rx_done_i(sie_rx_done_i), .sie_tx_rd_i(sie_tx_rd_i),
      .sie_tx_done_i(sie_tx_done_i), .sie_tx_data_o(sie_tx_data_o), .sie_tx_len_o(sie_tx_len_o),
      .sie_tx_ready_o(sie_tx_ready_o));
   ufd_host_model host (.clock_i(clock_i), .access_pending_i(access_pending_o), .rd_data_i(data_o),
      .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .addr_o(addr_i), .byte_hi_n_o(byte_hi_n_i),
      .wr_data_o(data_i));

   initial begin
      clock_i = 1'h0;
      forever #5 clock_i = ~clock_i;
   end

   // ======
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task give_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // timeout sized well above the whole sequence
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic wait_idle();
      int n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (access_pending_o !== 1'h0 && n < 100);
      check("pending", access_pending_o, 0);
      @(negedge clock_i);
   endtask : wait_idle

   task automatic fill_out(input int n);
      @(negedge clock_i);
      endpoint_direction_i = 1'h0;
      repeat (n) begin
         @(negedge clock_i);
         sie_rx_valid_i = 1'h1;
         sie_rx_data_i = 8'(rnd());
         q.push_back(sie_rx_data_i);
         @(negedge clock_i);
         sie_rx_valid_i = 1'h0;
      end
   endtask : fill_out

   task automatic rx_done();
      @(negedge clock_i);
      sie_rx_done_i = 1'h1;
      @(negedge clock_i);
      sie_rx_done_i = 1'h0;
   endtask : rx_done

   task automatic drain_out();
      logic [15:0] exp;
      int nb;
      wait_idle();
      check("buffer valid", buffer_valid_o, 1);
      while (q.size() > 0) begin
         check("byte count", receive_byte_count_o, q.size());
         nb = (w8 || q.size() == 1) ? 1 : 2;
         exp = (nb == 1) ? {8'h00, q[0]} : {q[1], q[0]};
         host.access(1'h1, 1'h0, 16'h0000, 1'h1, rd_word);
         check("read data", rd_word, exp);
         repeat (nb) void'(q.pop_front());
         wait_idle();
      end
      check("byte count", receive_byte_count_o, 0);
   endtask : drain_out

   task automatic fill_in(input int n, input logic odd);
      logic [15:0] w;
      @(negedge clock_i);
      endpoint_direction_i = 1'h1;
      for (int i = 0; i < n + odd; i++) begin
         w = 16'(rnd());
         host.access(1'h0, i == n, w, 1'h1, rd_word);
         q.push_back(w[7:0]);
         if (!w8 && i < n) q.push_back(w[15:8]);
      end
   endtask : fill_in

   task automatic send_in();
      @(negedge clock_i);
      buffer_valid_set_i = 1'h1;
      @(negedge clock_i);
      buffer_valid_set_i = 1'h0;
      repeat (2) @(negedge clock_i);
      check("tx ready", sie_tx_ready_o, 1);
      check("tx length", sie_tx_len_o, q.size());
      while (q.size() > 0) begin
         sie_tx_rd_i = 1'h1;
         @(negedge clock_i);
         sie_tx_rd_i = 1'h0;
         check("tx byte", sie_tx_data_o, q.pop_front());
         @(negedge clock_i);
      end
      sie_tx_done_i = 1'h1;
      @(negedge clock_i);
      sie_tx_done_i = 1'h0;
      repeat (3) @(negedge clock_i);
      check("tx ready", sie_tx_ready_o, 0);
   endtask : send_in

   // ======
   // main sequence
   initial begin
      {rst_n_i, bus_width_8_i, endpoint_direction_i, buffer_valid_set_i} = 4'h0;
      {sie_rx_valid_i, sie_rx_done_i, sie_tx_rd_i, sie_tx_done_i} = 4'h0;
      sie_rx_data_i = 8'h00;
      byte_width_pin_n_i = 1'h1;
      repeat (10) @(negedge clock_i);
      rst_n_i = 1'h1;
      check("pending", access_pending_o, 0);
      fill_in(3, 1'h1);
      host.access(1'h1, 1'h0, 16'h0000, 1'h1, rd_word);
      check("in read", rd_word, 0);
      send_in();
      $display("test odd in packet done");
      send_in();
      $display("test zero length done");
      fill_out(5);
      host.access(1'h1, 1'h0, 16'h0000, 1'h0, rd_word);
      check("refused read", rd_word, 0);
      rx_done();
      // a write on an out endpoint must leave the count alone
      host.access(1'h0, 1'h0, 16'h5A5A, 1'h1, rd_word);
      drain_out();
      $display("test out packet done");
      for (int m = 0; m < 2; m++) begin
         @(negedge clock_i);
         bus_width_8_i = (m == 0);
         byte_width_pin_n_i = (m == 0);
         fill_out(3);
         // engine still owns the buffer: the read is swallowed and returns zero
         host.access(1'h1, 1'h0, 16'h0000, 1'h0, rd_word);
         check("refused read", rd_word, 0);
         rx_done();
         drain_out();
         fill_in(2, 1'h0);
         host.access(1'h1, 1'h0, 16'h0000, 1'h1, rd_word);
         check("in read", rd_word, 0);
         send_in();
         $display("test byte mode %0d done", m);
      end
      give_verdict();
   end
endmodule : tb_top
